// ==== pkg/lpw_pkg.sv ====
// Purpose: Constants and types for the low-power wake-up controller
// Assumes: 25 MHz reference clock, APB with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package lpw_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned RESTART_NS      = 2000;
   localparam int unsigned RESTART_CYC     =
      (RESTART_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned SEQ_STEP_CYC    = 4;
   localparam int unsigned CNT_W           = 8;

   // ------------------------------------------------------------
   // Wake-up sources
   // ------------------------------------------------------------
   localparam int unsigned NUM_PINS        = 16;
   localparam int unsigned NUM_SRC         = 20;
   localparam int unsigned SRC_SUPPLY      = 16;
   localparam int unsigned SRC_CAL         = 17;
   localparam int unsigned SRC_TIMER       = 18;
   localparam int unsigned SRC_USB         = 19;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL        = 12'h000;
   localparam logic [11:0] OFS_WAKE_EN     = 12'h004;
   localparam logic [11:0] OFS_PWR_EN      = 12'h008;
   localparam logic [11:0] OFS_STATUS      = 12'h00C;
   localparam logic [11:0] OFS_CAUSE       = 12'h010;

   // CTRL fields
   localparam int unsigned CTRL_DEEP       = 0;
   localparam int unsigned CTRL_LPM        = 1;
   localparam int unsigned CTRL_RC_LO      = 2;
   localparam int unsigned CTRL_RC_HI      = 3;
   // PWR_EN fields
   localparam int unsigned PWR_CORE        = 0;
   localparam int unsigned PWR_SRAM        = 1;
   localparam int unsigned PWR_REG         = 2;
   localparam int unsigned PWR_PERCLK      = 3;

   localparam logic [3:0]  CTRL_RST        = 4'h0;
   localparam logic [19:0] WAKE_EN_RST     = 20'h00000;
   localparam logic [3:0]  PWR_EN_RST      = 4'hF;

   // Fast RC frequency selection
   localparam logic [1:0]  RC_4MHZ         = 2'h0;
   localparam logic [1:0]  RC_8MHZ         = 2'h1;
   localparam logic [1:0]  RC_12MHZ        = 2'h2;

   typedef enum logic [2:0] {
      ST_ACTIVE  = 3'h0,
      ST_SLEEP   = 3'h1,
      ST_WAIT    = 3'h2,
      ST_BACKUP  = 3'h3,
      ST_PWR_UP  = 3'h4,
      ST_RESTART = 3'h5
   } lpw_state_t;
endpackage

// ==== src/lpw_wake_detect.sv ====
// Purpose: Clockless fast-restart detector over the wake-up inputs
// Assumes: Inputs are active low, enables are static while sleeping
// Notes:   Pure combinational so no clock is needed to raise the request
`timescale 1ns/10ps
module lpw_wake_detect (
   // Sources
   input  wire logic [19:0] src_n_i,
   input  wire logic [19:0] en_i,
   // Result
   output logic      [19:0] hit_o,
   output logic             fast_req_o
);
   // ------------------------------------------------------------
   // Detection
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < lpw_pkg::NUM_SRC; g++) begin : g_src
         assign hit_o[g] = ~src_n_i[g] & en_i[g]; // R03
      end
   endgenerate

   assign fast_req_o = |hit_o; // R04
endmodule

// ==== src/lpw_apb_regs.sv ====
// Purpose: APB slave holding control, enable and status words
// Assumes: Zero-wait APB, 32-bit data
// Notes:   Unmapped addresses read zero and raise pslverr
`timescale 1ns/10ps
module lpw_apb_regs (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   // APB
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Register contents
   output logic      [3:0]  ctrl_o,
   output logic      [19:0] wake_en_o,
   output logic      [3:0]  pwr_en_o,
   // Status inputs
   input  wire logic [31:0] status_i,
   input  wire logic [19:0] cause_i,
   output logic             cause_rd_o
);
   typedef struct packed {
      logic [3:0]  ctrl;
      logic [19:0] wake_en;
      logic [3:0]  pwr_en;
      logic [31:0] rdata;
      logic        err;
   } lpw_reg_t;

   lpw_reg_t st_ff;
   lpw_reg_t nxt_st;
   logic     acc;
   logic     hit;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   assign acc = psel_i & ~penable_i;
   always_comb begin
      unique case (paddr_i)
         lpw_pkg::OFS_CTRL, lpw_pkg::OFS_WAKE_EN, lpw_pkg::OFS_PWR_EN,
         lpw_pkg::OFS_STATUS, lpw_pkg::OFS_CAUSE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      if (acc) begin
         nxt_st.err   = ~hit;
         nxt_st.rdata = 32'h00000000;
         if (pwrite_i) begin
            unique case (paddr_i)
               lpw_pkg::OFS_CTRL:    nxt_st.ctrl    = pwdata_i[3:0];
               lpw_pkg::OFS_WAKE_EN: nxt_st.wake_en = pwdata_i[19:0]; // R01
               lpw_pkg::OFS_PWR_EN:  nxt_st.pwr_en  = pwdata_i[3:0];  // R01
               default: ;
            endcase
         end else begin
            unique case (paddr_i)
               lpw_pkg::OFS_CTRL:    nxt_st.rdata = {28'h0000000, st_ff.ctrl};
               lpw_pkg::OFS_WAKE_EN: nxt_st.rdata = {12'h000, st_ff.wake_en};
               lpw_pkg::OFS_PWR_EN:  nxt_st.rdata = {28'h0000000, st_ff.pwr_en};
               lpw_pkg::OFS_STATUS:  nxt_st.rdata = status_i;
               lpw_pkg::OFS_CAUSE:   nxt_st.rdata = {12'h000, cause_i};
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_ff <= '{ctrl: lpw_pkg::CTRL_RST, wake_en: lpw_pkg::WAKE_EN_RST,
                    pwr_en: lpw_pkg::PWR_EN_RST, rdata: 32'h00000000,
                    err: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Access phase answers one cycle after setup, data already latched
   assign pready_o   = psel_i & penable_i;
   assign pslverr_o  = psel_i & penable_i & st_ff.err;
   assign prdata_o   = st_ff.rdata;
   assign ctrl_o     = st_ff.ctrl;
   assign wake_en_o  = st_ff.wake_en;
   assign pwr_en_o   = st_ff.pwr_en;
   assign cause_rd_o = acc & ~pwrite_i & (paddr_i == lpw_pkg::OFS_CAUSE);
endmodule

// ==== src/lpw_wakeup_ctrl.sv ====
// Purpose: Low-power mode entry and wake-up sequencer
// Assumes: Core signals and wake-up inputs synchronous to ref_clk_i
// Notes:   Fast request path is clockless; sequencing is clocked
//
// Overview of operation
// R01: Power regions and wake sources individually enabled
// R02: Backup wake re-enables core and SRAM supplies
// R03: Low level on enabled input starts restart
// R04: Fast request formed without any clock
// R05: Restart fast RC, switch master clock, clock core
// R06: Wake on fast RC, never restart PLL
// R07: Software restarts PLL itself if needed
// R08: Sleep keeps core powered, peripheral clocks optional
// R09: Wait wakes on pins, alarms, USB; pins kept
// R10: Fast restart only from wait or sleep
// R11: Event instruction with deep select enters backup
// R12: Backup exits on pins, supply, timer, calendar
// R13: Backup turns off regulator and core supply
// R14: Backup wake sets io lines input pulled up
// R15: Low-power select picks wait, else sleep
// R16: Interrupt-entered sleep wakes on interrupt only
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module lpw_wakeup_ctrl (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   // APB
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Core
   input  wire logic        wait_for_event_instr_i,
   input  wire logic        wait_for_interrupt_instr_i,
   input  wire logic        irq_pending_i,
   output logic             core_clk_en_o,
   output logic             core_reset_o,
   // Wake-up sources, active low
   input  wire logic [15:0] wakeup_pins_n_i,
   input  wire logic        supply_monitor_alarm_n_i,
   input  wire logic        calendar_alarm_n_i,
   input  wire logic        real_time_timer_alarm_n_i,
   input  wire logic        usb_wakeup_n_i,
   // Supplies
   output logic             regulator_en_o,
   output logic             core_supply_en_o,
   output logic             sram_supply_en_o,
   output logic             backup_region_on_o,
   output logic             periph_clk_en_o,
   // Clock manager
   output logic             fast_startup_o,
   output logic             fast_rc_en_o,
   output logic      [1:0]  fast_rc_sel_o,
   output logic             master_clk_on_rc_o,
   output logic             pll_en_o,
   // IO lines
   output logic             io_line_force_input_o,
   output logic             io_line_pullup_o
);
   typedef struct packed {
      lpw_pkg::lpw_state_t        state;
      logic                       by_wfi;
      logic                       core_on;
      logic                       sram_on;
      logic                       reg_on;
      logic                       clk_en;
      logic                       rc_on;
      logic                       mck_rc;
      logic                       io_reset;
      logic                       core_rst;
      logic [lpw_pkg::CNT_W-1:0]  cnt;
      logic [19:0]                cause;
   } lpw_st_t;

   lpw_st_t     st_ff;
   lpw_st_t     nxt_st;
   logic [3:0]  ctrl;
   logic [19:0] wake_en;
   logic [3:0]  pwr_en;
   logic [19:0] src_n;
   logic [19:0] en_mode;
   logic [19:0] hit;
   logic        fast_req;
   logic        cause_rd;
   logic [31:0] status;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   lpw_apb_regs u_regs (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .psel_i     (psel_i),
      .penable_i  (penable_i),
      .pwrite_i   (pwrite_i),
      .paddr_i    (paddr_i),
      .pwdata_i   (pwdata_i),
      .prdata_o   (prdata_o),
      .pready_o   (pready_o),
      .pslverr_o  (pslverr_o),
      .ctrl_o     (ctrl),
      .wake_en_o  (wake_en),
      .pwr_en_o   (pwr_en),
      .status_i   (status),
      .cause_i    (st_ff.cause),
      .cause_rd_o (cause_rd)
   );

   assign status = {25'h0000000, st_ff.io_reset, st_ff.mck_rc,
                    st_ff.rc_on, st_ff.state, 1'b0};

   // ------------------------------------------------------------
   // Wake source selection per mode
   // ------------------------------------------------------------
   assign src_n = {usb_wakeup_n_i, real_time_timer_alarm_n_i,
                   calendar_alarm_n_i, supply_monitor_alarm_n_i,
                   wakeup_pins_n_i};

   always_comb begin
      en_mode = 20'h00000;
      unique case (st_ff.state)
         // Backup: pins, supply monitor, calendar, timer
         lpw_pkg::ST_BACKUP: en_mode = wake_en & 20'h7FFFF; // R12
         // Wait and event-entered sleep: pins, calendar and timer alarms, USB
         lpw_pkg::ST_WAIT:   en_mode = wake_en & 20'hEFFFF; // R09 R10
         lpw_pkg::ST_SLEEP:
            en_mode = st_ff.by_wfi ? 20'h00000 : (wake_en & 20'hEFFFF); // R16
         default: en_mode = 20'h00000;
      endcase
   end

   lpw_wake_detect u_det (
      .src_n_i    (src_n),
      .en_i       (en_mode),
      .hit_o      (hit),
      .fast_req_o (fast_req)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
      // Reading the cause clears it, but a new hit wins
      if (cause_rd) begin
         nxt_st.cause = 20'h00000;
      end
      nxt_st.cause = nxt_st.cause | hit;
      unique case (st_ff.state)
         lpw_pkg::ST_ACTIVE: begin
            nxt_st.io_reset = 1'b0;
            nxt_st.core_rst = 1'b0;
            nxt_st.core_on  = pwr_en[lpw_pkg::PWR_CORE]; // R01
            nxt_st.sram_on  = pwr_en[lpw_pkg::PWR_SRAM];
            nxt_st.reg_on   = pwr_en[lpw_pkg::PWR_REG];
            if (wait_for_event_instr_i && ctrl[lpw_pkg::CTRL_DEEP]) begin
               nxt_st.state   = lpw_pkg::ST_BACKUP; // R11
               nxt_st.reg_on  = 1'b0; // R13
               nxt_st.core_on = 1'b0; // R13
               nxt_st.sram_on = 1'b0;
               nxt_st.clk_en  = 1'b0;
               nxt_st.rc_on   = 1'b0;
            end else if (wait_for_event_instr_i &&
                         ctrl[lpw_pkg::CTRL_LPM]) begin
               nxt_st.state  = lpw_pkg::ST_WAIT; // R15
               nxt_st.clk_en = 1'b0;
               nxt_st.rc_on  = 1'b0;
            end else if (wait_for_event_instr_i ||
                         wait_for_interrupt_instr_i) begin
               nxt_st.state  = lpw_pkg::ST_SLEEP; // R15
               nxt_st.by_wfi = ~wait_for_event_instr_i;
               nxt_st.clk_en = 1'b0; // R08
            end
         end
         lpw_pkg::ST_SLEEP: begin
            if (irq_pending_i || fast_req) begin // R16
               nxt_st.state  = lpw_pkg::ST_ACTIVE;
               nxt_st.clk_en = 1'b1;
            end
         end
         lpw_pkg::ST_WAIT: begin
            if (fast_req) begin
               nxt_st.state  = lpw_pkg::ST_RESTART; // R05
               nxt_st.rc_on  = 1'b1;
               nxt_st.mck_rc = 1'b1; // R06
               nxt_st.cnt    = lpw_pkg::CNT_W'(lpw_pkg::RESTART_CYC);
            end
         end
         lpw_pkg::ST_RESTART: begin
            if (st_ff.cnt == '0) begin
               nxt_st.state  = lpw_pkg::ST_ACTIVE;
               nxt_st.clk_en = 1'b1; // R05
            end
         end
         lpw_pkg::ST_BACKUP: begin
            if (fast_req) begin
               nxt_st.state    = lpw_pkg::ST_PWR_UP;
               nxt_st.reg_on   = 1'b1;
               nxt_st.core_rst = 1'b1;
               nxt_st.cnt      = lpw_pkg::CNT_W'(lpw_pkg::SEQ_STEP_CYC);
            end
         end
         lpw_pkg::ST_PWR_UP: begin
            if (st_ff.cnt == '0) begin
               nxt_st.core_on  = 1'b1; // R02
               nxt_st.sram_on  = 1'b1; // R02
               nxt_st.rc_on    = 1'b1;
               nxt_st.mck_rc   = 1'b1; // R06
               nxt_st.io_reset = 1'b1; // R14
               nxt_st.clk_en   = 1'b1;
               nxt_st.state    = lpw_pkg::ST_ACTIVE;
            end
         end
         default: nxt_st.state = lpw_pkg::ST_ACTIVE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_ff <= '{state: lpw_pkg::ST_ACTIVE, by_wfi: 1'b0, core_on: 1'b1,
                    sram_on: 1'b1, reg_on: 1'b1, clk_en: 1'b1,
                    rc_on: 1'b1, mck_rc: 1'b1, io_reset: 1'b0,
                    core_rst: 1'b0, cnt: '0, cause: 20'h00000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Backup wake goes through the supply sequencer, not the clock manager
   assign fast_startup_o        = fast_req &
                                  (st_ff.state != lpw_pkg::ST_BACKUP); // R04 R10
   assign core_clk_en_o         = st_ff.clk_en;
   assign core_reset_o          = st_ff.core_rst;
   assign regulator_en_o        = st_ff.reg_on;
   assign core_supply_en_o      = st_ff.core_on;
   assign sram_supply_en_o      = st_ff.sram_on;
   assign backup_region_on_o    = 1'b1; // R13
   assign periph_clk_en_o       = pwr_en[lpw_pkg::PWR_PERCLK] &
                                  (st_ff.state != lpw_pkg::ST_BACKUP); // R08
   assign fast_rc_en_o          = st_ff.rc_on;
   assign fast_rc_sel_o         = ctrl[lpw_pkg::CTRL_RC_HI:lpw_pkg::CTRL_RC_LO];
   assign master_clk_on_rc_o    = st_ff.mck_rc;
   // PLL is left to software; hardware never asserts it
   assign pll_en_o              = 1'b0; // R06 R07
   assign io_line_force_input_o = st_ff.io_reset; // R14
   assign io_line_pullup_o      = st_ff.io_reset;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   backup_entry_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_ACTIVE && wait_for_event_instr_i && ctrl[0]
      |=> st_ff.state == lpw_pkg::ST_BACKUP && !regulator_en_o) // R11
      else $error("backup not entered");
   backup_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_BACKUP |-> !core_supply_en_o
      && !regulator_en_o && backup_region_on_o) // R13
      else $error("supply on in backup");
   wait_entry_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_ACTIVE && wait_for_event_instr_i
      && !ctrl[0] && ctrl[1] |=> st_ff.state == lpw_pkg::ST_WAIT) // R15
      else $error("wait not entered");
   fast_req_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_WAIT && (|(~wakeup_pins_n_i & wake_en[15:0]))
      |-> fast_startup_o) // R03
      else $error("fast startup missing");
   restart_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_WAIT && fast_req |=> fast_rc_en_o
      && master_clk_on_rc_o ##[1:60] core_clk_en_o) // R05
      else $error("restart sequence failed");
   pll_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(core_clk_en_o) |-> !pll_en_o && master_clk_on_rc_o) // R06
      else $error("pll restarted by hardware");
   backup_wake_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_BACKUP && fast_req
      |-> ##[1:8] core_supply_en_o && sram_supply_en_o) // R02 R12
      else $error("supplies not restored");
   io_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_PWR_UP ##1 st_ff.state == lpw_pkg::ST_ACTIVE
      |-> io_line_force_input_o && io_line_pullup_o) // R14
      else $error("io lines not reset");
   wfi_sleep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_SLEEP && st_ff.by_wfi && !irq_pending_i
      |=> st_ff.state == lpw_pkg::ST_SLEEP) // R16
      else $error("wfi sleep woke without irq");
   sleep_clk_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_SLEEP |-> !core_clk_en_o
      && core_supply_en_o == pwr_en[0] && !fast_rc_en_o == 1'b0) // R08
      else $error("sleep clock state wrong");
   no_fast_active_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_ACTIVE |-> !fast_startup_o) // R10
      else $error("fast startup while active");
   src_enable_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !wake_en[0] && $stable(wake_en) |-> !hit[0]) // R01
      else $error("disabled source hit");
   usb_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_ff.state == lpw_pkg::ST_WAIT && !usb_wakeup_n_i && wake_en[19]
      |=> st_ff.state == lpw_pkg::ST_RESTART) // R09
      else $error("usb did not wake wait");
endmodule

// ==== dv/lpw_core_model.sv ====
// Purpose: Core model that issues low-power entry instructions
// Assumes: Bench raises a request for one cycle to run an instruction
// Notes:   A core whose clock is gated executes nothing
`timescale 1ns/10ps
module lpw_core_model (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // Requests from the bench
   input  wire logic evt_req_i,
   input  wire logic int_req_i,
   // Clock gate from the controller
   input  wire logic core_clk_en_i,
   // Instructions to the controller
   output logic      evt_instr_o,
   output logic      int_instr_o
);
   // -------------------------------------------------------------
   // Instruction issue
   // -------------------------------------------------------------
   // Core never needs the PLL here, so no start-up wait is added
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         evt_instr_o <= 1'b0;
         int_instr_o <= 1'b0;
      end else begin
         evt_instr_o <= evt_req_i & core_clk_en_i;
         int_instr_o <= int_req_i & core_clk_en_i;
      end
   end
endmodule

// ==== dv/lpw_wakeup_ctrl_tb.sv ====
// Purpose: Self-checking bench for the low-power wake-up controller
// Assumes: Zero-wait APB, instructions issued through the core model
// Notes:   Register table first, then sleep, wait and backup cases
`timescale 1ns/10ps
module lpw_wakeup_ctrl_tb;
   typedef struct {
      logic [11:0] addr;
      logic [31:0] wdat;
      logic [31:0] rexp;
      logic        err;
   } lpw_row_t;
   logic        ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
   logic        irq_pending_i, evt_req, int_req, io_seen, er;
   logic        wait_for_event_instr_i, wait_for_interrupt_instr_i;
   logic        supply_monitor_alarm_n_i, calendar_alarm_n_i;
   logic        real_time_timer_alarm_n_i, usb_wakeup_n_i;
   logic        pready_o, pslverr_o, core_clk_en_o, core_reset_o;
   logic        regulator_en_o, core_supply_en_o, sram_supply_en_o;
   logic        backup_region_on_o, periph_clk_en_o, fast_startup_o;
   logic        fast_rc_en_o, master_clk_on_rc_o, pll_en_o;
   logic        io_line_force_input_o, io_line_pullup_o;
   logic [1:0]  fast_rc_sel_o;
   logic [11:0] paddr_i;
   logic [15:0] wakeup_pins_n_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   int          errors = 0, n_checks = 0, n;
   lpw_row_t    rows [5] = '{
      '{lpw_pkg::OFS_CTRL,    32'hFFFFFFFB, 32'h0000000B, 1'b0},
      '{lpw_pkg::OFS_WAKE_EN, 32'hFFFFFFFF, 32'h000FFFFF, 1'b0},
      '{lpw_pkg::OFS_PWR_EN,  32'hFFFFFFF5, 32'h00000005, 1'b0},
      '{lpw_pkg::OFS_STATUS,  32'hFFFFFFFF, 32'h00000030, 1'b0},
      '{12'h014,              32'hFFFFFFFF, 32'h00000000, 1'b1}};

   lpw_core_model i_core (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .evt_req_i(evt_req),
      .int_req_i(int_req), .core_clk_en_i(core_clk_en_o),
      .evt_instr_o(wait_for_event_instr_i),
      .int_instr_o(wait_for_interrupt_instr_i));
   lpw_wakeup_ctrl i_dut (
      .ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .wait_for_event_instr_i, .wait_for_interrupt_instr_i, .irq_pending_i,
      .core_clk_en_o, .core_reset_o, .wakeup_pins_n_i,
      .supply_monitor_alarm_n_i, .calendar_alarm_n_i,
      .real_time_timer_alarm_n_i, .usb_wakeup_n_i, .regulator_en_o,
      .core_supply_en_o, .sram_supply_en_o, .backup_region_on_o,
      .periph_clk_en_o, .fast_startup_o, .fast_rc_en_o, .fast_rc_sel_o,
      .master_clk_on_rc_o, .pll_en_o, .io_line_force_input_o,
      .io_line_pullup_o);

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Access waits for pready under a bound, no fixed latency assumed
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) errors++;
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      #1;
   endtask
   task automatic instr(input logic evt);
      @(posedge ref_clk_i);
      evt_req <= evt;
      int_req <= !evt;
      @(posedge ref_clk_i);
      evt_req <= 1'b0;
      int_req <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask
   // Waits for the core clock, noting the io line state on the way
   task automatic wait_en(input int lim);
      n = 0;
      io_seen = 1'b0;
      while (core_clk_en_o !== 1'b1 && n < lim) begin
         @(posedge ref_clk_i);
         #1;
         n++;
         if (io_line_pullup_o === 1'b1 && io_line_force_input_o === 1'b1)
            io_seen = 1'b1;
      end
   endtask

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      #(40 * 4000);
      errors++;
      report_and_stop();
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {psel_i, penable_i, pwrite_i, irq_pending_i, evt_req, int_req} = 6'h0;
      {supply_monitor_alarm_n_i, calendar_alarm_n_i, usb_wakeup_n_i} = 3'h7;
      {real_time_timer_alarm_n_i, wakeup_pins_n_i} = 17'h1FFFF;
      {paddr_i, pwdata_i} = 44'h0;
      rst_n_i = 1'b0;
      repeat (5) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, lpw_pkg::OFS_PWR_EN, 32'h0);
      chk(rd, 32'h0000000F);
      chk_b(pll_en_o, 1'b0);
      chk_b(backup_region_on_o, 1'b1);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].addr, rows[i].wdat);
         apb(1'b0, rows[i].addr, 32'h0);
         chk(rd, rows[i].rexp);
         chk_b(er, rows[i].err);
      end
      chk({sram_supply_en_o, regulator_en_o, periph_clk_en_o}, 3'h2);
      chk(fast_rc_sel_o, lpw_pkg::RC_12MHZ);
      apb(1'b1, lpw_pkg::OFS_PWR_EN, 32'h0000000F);
      // Sleep entered by interrupt instruction: pins are ignored
      apb(1'b1, lpw_pkg::OFS_CTRL, 32'h0);
      apb(1'b1, lpw_pkg::OFS_WAKE_EN, 32'h00000008);
      instr(1'b0);
      chk({core_clk_en_o, core_supply_en_o, periph_clk_en_o}, 3'h3);
      wakeup_pins_n_i <= 16'hFFF7;
      wait_en(6);
      chk_b(core_clk_en_o, 1'b0);
      irq_pending_i <= 1'b1;
      wait_en(10);
      chk_b(core_clk_en_o, 1'b1);
      irq_pending_i <= 1'b0;
      wakeup_pins_n_i <= 16'hFFFF;
      // Sleep entered by event instruction: disabled pin, then enabled pin
      instr(1'b1);
      @(posedge ref_clk_i);
      wakeup_pins_n_i <= 16'hFFEF;
      wait_en(6);
      chk_b(core_clk_en_o, 1'b0);
      @(posedge ref_clk_i);
      wakeup_pins_n_i <= 16'hFFE7;
      #1;
      chk_b(fast_startup_o, 1'b1);
      wait_en(20);
      chk_b(core_clk_en_o, 1'b1);
      wakeup_pins_n_i <= 16'hFFFF;
      // Wait mode: supply alarm is no wait source, calendar is
      apb(1'b1, lpw_pkg::OFS_CTRL, 32'h00000006);
      apb(1'b1, lpw_pkg::OFS_WAKE_EN, 32'h00030000);
      instr(1'b1);
      supply_monitor_alarm_n_i <= 1'b0;
      wait_en(6);
      chk({fast_startup_o, core_clk_en_o}, 2'h0);
      @(posedge ref_clk_i);
      supply_monitor_alarm_n_i <= 1'b1;
      calendar_alarm_n_i <= 1'b0;
      #1;
      chk_b(fast_startup_o, 1'b1);
      wait_en(80);
      chk_b(n >= lpw_pkg::RESTART_CYC - 2, 1'b1);
      chk_b(n <= lpw_pkg::RESTART_CYC + 4, 1'b1);
      chk({fast_rc_en_o, master_clk_on_rc_o, pll_en_o}, 3'h6);
      chk(fast_rc_sel_o, lpw_pkg::RC_8MHZ);
      calendar_alarm_n_i <= 1'b1;
      // Backup: usb is no backup source, timer alarm is
      apb(1'b1, lpw_pkg::OFS_CTRL, 32'h00000001);
      apb(1'b1, lpw_pkg::OFS_WAKE_EN, 32'h000C0000);
      instr(1'b1);
      chk({regulator_en_o, core_supply_en_o, backup_region_on_o}, 3'h1);
      usb_wakeup_n_i <= 1'b0;
      wait_en(6);
      chk_b(core_clk_en_o, 1'b0);
      @(posedge ref_clk_i);
      usb_wakeup_n_i <= 1'b1;
      real_time_timer_alarm_n_i <= 1'b0;
      #1;
      chk_b(fast_startup_o, 1'b0);
      wait_en(30);
      chk({core_clk_en_o, core_supply_en_o, sram_supply_en_o}, 3'h7);
      chk_b(io_seen, 1'b1);
      real_time_timer_alarm_n_i <= 1'b1;
      apb(1'b0, lpw_pkg::OFS_CAUSE, 32'h0);
      chk(rd, 32'h00060008);
      report_and_stop();
   end
endmodule
